// >>> otl_accum.sv
// one elapsed-time accumulator: seconds and tenths of an hour
// assumes a one-cycle tick once a second and a synchronous clear
`timescale 1ns/100ps
`default_nettype none
module otl_accum
  import otl_pkg::*;
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // control
  input  wire logic              i_tick,
  input  wire logic              i_enable,
  input  wire logic              i_clear,
  // accumulated time
  output logic      [TIME_W-1:0] o_tenths,
  output logic      [TIME_W-1:0] o_secs
);

  logic [SUB_W-1:0] sub;
  logic             step;

  assign step = i_tick && i_enable && !i_clear;

  // ***************************************************************
  // seconds within the current tenth of an hour
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sub <= SUB_ZERO;
    end else if (i_clear) begin
      sub <= SUB_ZERO;
    end else if (step) begin
      sub <= (sub == SUB_LAST) ? SUB_ZERO : sub + SUB_ONE;
    end
  end

  // ***************************************************************
  // tenths of an hour, decimal fraction, saturating
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_tenths <= TIME_ZERO;
    end else if (i_clear) begin
      o_tenths <= TIME_ZERO;
    end else if (step && sub == SUB_LAST && o_tenths != TENTHS_MAX) begin
      o_tenths <= o_tenths + TIME_ONE;
    end
  end

  // ***************************************************************
  // whole seconds, saturating at the display switch point
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_secs <= TIME_ZERO;
    end else if (i_clear) begin
      o_secs <= TIME_ZERO;
    end else if (step && o_secs != SEC_MAX) begin
      o_secs <= o_secs + TIME_ONE;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  hold_when_idle_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_enable && !i_clear |=> o_tenths == $past(o_tenths) && o_secs == $past(o_secs))
    else $error("counter moved while not enabled");

  clear_all_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_clear |=> o_tenths == TIME_ZERO && o_secs == TIME_ZERO && sub == SUB_ZERO)
    else $error("clear did not zero the counter");

  never_down_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    !i_clear |=> o_tenths >= $past(o_tenths) && o_secs >= $past(o_secs))
    else $error("counter decreased without clear");

  tenth_step_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    step && sub == SUB_LAST && o_tenths != TENTHS_MAX |=> o_tenths == $past(o_tenths) + TIME_ONE)
    else $error("tenth step missed after 360 seconds");

  no_early_tenth_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    sub != SUB_LAST && !i_clear |=> o_tenths == $past(o_tenths))
    else $error("tenth advanced before 360 seconds");

  saturate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_tenths <= TENTHS_MAX && o_secs <= SEC_MAX)
    else $error("counter passed its limit");

endmodule
`default_nettype wire

// >>> otl_logger.sv
// operating-time logger: operating hours plus six comparator run times
// assumes synchronous inputs; the clear command comes only from the host
//
// Overview of operation
// - operating hours count tenths while acquiring
// - operating hours can be cleared only by reset
// - comparator time accumulates only during violation
// - indices 1..6 map 1A,2A,1B,2B,1C,2C
// - seconds shown below 999,999, then hours
// - displayed hours limited to 99,999.9
// - host command clears all six together
// - hour fraction is decimal, 360 s tenth
// - two groups of three comparators A-C
`timescale 1ns/100ps
`default_nettype none
module otl_logger
  import otl_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEF
)
(
  // clock and reset
  input  wire logic              i_sys_clk,
  input  wire logic              i_rst_n,
  // device state
  input  wire logic              i_acquiring,
  // comparator results, bit 0 = A, high = violation
  input  wire logic      [CMP_PER_GROUP-1:0] i_cmp_viol_g1,
  input  wire logic      [CMP_PER_GROUP-1:0] i_cmp_viol_g2,
  // host reset command for all comparator times
  input  wire logic              i_cmp_clear,
  // display query
  input  wire logic  [SEL_W-1:0] i_sel,
  // display answer
  output logic      [TIME_W-1:0] o_disp_value,
  output logic                   o_disp_hours,
  output logic      [TIME_W-1:0] o_op_tenths
);

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_ONE  = 24'h000001;
  localparam logic [TICK_W-1:0] TICK_ZERO = 24'h000000;

  generate
    if (TICK_CYCLES < 1 || TICK_CYCLES > (1 << TICK_W)) begin : g_bad_tick
      $error("TICK_CYCLES out of range");
    end
  endgenerate

  logic [TICK_W-1:0] tick_cnt;
  logic              tick;
  logic [TIME_W-1:0] cmp_tenths [1:CMP_NUM];
  logic [TIME_W-1:0] cmp_secs   [1:CMP_NUM];
  logic [TIME_W-1:0] next_disp_value;
  logic              next_disp_hours;

  // ***************************************************************
  // one-second time base
  // ***************************************************************
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick_cnt <= TICK_ZERO;
    end else if (tick_cnt == TICK_LAST) begin
      tick_cnt <= TICK_ZERO;
    end else begin
      tick_cnt <= tick_cnt + TICK_ONE;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= (tick_cnt == TICK_LAST);
    end
  end

  // ***************************************************************
  // operating hours counter
  // ***************************************************************
  otl_accum u_op (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_tick    (tick),
    .i_enable  (i_acquiring),
    .i_clear   (1'b0),
    .o_tenths  (o_op_tenths),
    .o_secs    ()
  );

  // ***************************************************************
  // comparator run-time accumulators
  // ***************************************************************
  generate
    for (genvar g = 0; g < GROUP_NUM; g++) begin : g_grp
      for (genvar l = 0; l < CMP_PER_GROUP; l++) begin : g_cmp
        localparam int unsigned IDX = cmp_index(g, l);
        otl_accum u_acc (
          .i_sys_clk (i_sys_clk),
          .i_rst_n   (i_rst_n),
          .i_tick    (tick),
          .i_enable  ((g == 0) ? i_cmp_viol_g1[l] : i_cmp_viol_g2[l]),
          .i_clear   (i_cmp_clear),
          .o_tenths  (cmp_tenths[IDX]),
          .o_secs    (cmp_secs[IDX])
        );
      end
    end
  endgenerate

  // ***************************************************************
  // display selection and unit switch-over
  // ***************************************************************
  always_comb begin
    next_disp_value = TIME_ZERO;
    next_disp_hours = 1'b0;
    if (i_sel == SEL_OP) begin
      next_disp_value = o_op_tenths;
      next_disp_hours = 1'b1;
    end else if (int'(i_sel) <= CMP_NUM) begin
      if (cmp_secs[i_sel] == SEC_MAX) begin
        next_disp_value = cmp_tenths[i_sel];
        next_disp_hours = 1'b1;
      end else begin
        next_disp_value = cmp_secs[i_sel];
        next_disp_hours = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_disp_value <= TIME_ZERO;
      o_disp_hours <= 1'b0;
    end else begin
      o_disp_value <= next_disp_value;
      o_disp_hours <= next_disp_hours;
    end
  end

  // ***************************************************************
  // checks
  // ***************************************************************
  tick_single_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    tick && TICK_CYCLES > 1 |=> !tick)
    else $error("tick longer than one cycle");

  op_in_hours_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_sel == SEL_OP |=> o_disp_hours && o_disp_value == $past(o_op_tenths))
    else $error("operating hours not shown in hours");

  index_map_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_sel == 3'h2 && g_grp[1].g_cmp[0].u_acc.o_secs != SEC_MAX |=>
      o_disp_value == $past(g_grp[1].g_cmp[0].u_acc.o_secs))
    else $error("index 2 does not show group 2 A");

  unit_switch_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    i_sel != SEL_OP && int'(i_sel) <= CMP_NUM |=>
      o_disp_hours == $past(cmp_secs[i_sel] == SEC_MAX))
    else $error("unit switch not at 999,999 seconds");

  disp_limit_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_disp_value <= TENTHS_MAX)
    else $error("displayed time beyond limit");

endmodule
`default_nettype wire

// >>> otl_logger_tb_top.sv
// self-checking testbench for the operating-time logger
// assumes the logger alone, driven straight from its ports, short tick
`timescale 1ns/100ps
`default_nettype none
module otl_logger_tb_top
  import otl_pkg::*;
;
  // ***************************************************************
  // stimulus and design
  // ***************************************************************
  localparam int unsigned TB_TICK = 2;
  logic                     i_sys_clk;
  logic                     i_rst_n;
  logic                     i_acquiring;
  logic [CMP_PER_GROUP-1:0] i_cmp_viol_g1;
  logic [CMP_PER_GROUP-1:0] i_cmp_viol_g2;
  logic                     i_cmp_clear;
  logic [SEL_W-1:0]         i_sel;
  logic [TIME_W-1:0]        o_disp_value;
  logic                     o_disp_hours;
  logic [TIME_W-1:0]        o_op_tenths;
  int                       fails;
  int                       check_count;

  otl_logger #(.TICK_CYCLES(TB_TICK)) dut_u (
    .i_sys_clk     (i_sys_clk),
    .i_rst_n       (i_rst_n),
    .i_acquiring   (i_acquiring),
    .i_cmp_viol_g1 (i_cmp_viol_g1),
    .i_cmp_viol_g2 (i_cmp_viol_g2),
    .i_cmp_clear   (i_cmp_clear),
    .i_sel         (i_sel),
    .o_disp_value  (o_disp_value),
    .o_disp_hours  (o_disp_hours),
    .o_op_tenths   (o_op_tenths)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // ***************************************************************
  // shared tasks
  // ***************************************************************
  task automatic check(input logic [TIME_W-1:0] seen, input logic [TIME_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // select an index and check value and unit
  task automatic show(input logic [SEL_W-1:0] sel, input logic [TIME_W-1:0] val,
                      input logic hrs);
    @(posedge i_sys_clk);
    i_sel <= sel;
    repeat (2) @(posedge i_sys_clk);
    #10;
    check(o_disp_value, val);
    check({19'h00000, o_disp_hours}, {19'h00000, hrs});
  endtask

  // hold one violation bit high for a number of edges
  task automatic viol(input int g, input int l, input int edges);
    @(posedge i_sys_clk);
    if (g == 0) begin
      i_cmp_viol_g1[l] <= 1'b1;
    end else begin
      i_cmp_viol_g2[l] <= 1'b1;
    end
    repeat (edges) @(posedge i_sys_clk);
    i_cmp_viol_g1 <= '0;
    i_cmp_viol_g2 <= '0;
  endtask

  task automatic acquire(input int edges);
    @(posedge i_sys_clk);
    i_acquiring <= 1'b1;
    repeat (edges) @(posedge i_sys_clk);
    i_acquiring <= 1'b0;
  endtask

  // ***************************************************************
  // scenarios
  // ***************************************************************
  task automatic sc_reset();
    show(SEL_OP, TIME_ZERO, 1'b1);
    for (int k = 1; k <= 7; k++) show(k[SEL_W-1:0], TIME_ZERO, 1'b0);
  endtask

  // exactly 360 seconds make one tenth, 359 do not
  task automatic sc_op_hours();
    acquire(360 * TB_TICK);
    repeat (4) @(posedge i_sys_clk);
    #10;
    check(o_op_tenths, TIME_ONE);
    show(SEL_OP, TIME_ONE, 1'b1);
    acquire(359 * TB_TICK);
    repeat (4) @(posedge i_sys_clk);
    #10;
    check(o_op_tenths, TIME_ONE);
    acquire(TB_TICK);
    repeat (4) @(posedge i_sys_clk);
    #10;
    check(o_op_tenths, 20'h00002);
    show(3'h1, TIME_ZERO, 1'b0);
  endtask

  // comparator k counts 2k seconds; letter*2+group+1 gives the index
  task automatic sc_cmp_map();
    for (int l = 0; l < 3; l++) begin
      for (int g = 0; g < 2; g++) begin
        viol(g, l, 2 * TB_TICK * (l * 2 + g + 1));
        repeat (30) @(posedge i_sys_clk);
      end
    end
    for (int k = 1; k <= 6; k++) show(k[SEL_W-1:0], TIME_W'(2 * k), 1'b0);
    check(o_op_tenths, 20'h00002);
  endtask

  // one clear empties all six, operating hours untouched; clear beats a tick
  task automatic sc_clear();
    @(posedge i_sys_clk);
    i_cmp_clear <= 1'b1;
    i_cmp_viol_g1 <= '1;
    repeat (2) @(posedge i_sys_clk);
    i_cmp_clear <= 1'b0;
    i_cmp_viol_g1 <= '0;
    for (int k = 1; k <= 6; k++) show(k[SEL_W-1:0], TIME_ZERO, 1'b0);
    check(o_op_tenths, 20'h00002);
    viol(1, 2, 3 * TB_TICK);
    repeat (6) @(posedge i_sys_clk);
    show(3'h6, 20'h00003, 1'b0);
  endtask

  // ***************************************************************
  // main sequence and watchdog
  // ***************************************************************
  initial begin
    fails = 0;
    check_count = 0;
    i_rst_n = 1'b0;
    i_acquiring = 1'b0;
    i_cmp_viol_g1 = '0;
    i_cmp_viol_g2 = '0;
    i_cmp_clear = 1'b0;
    i_sel = SEL_OP;
    repeat (4) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    sc_reset();
    sc_op_hours();
    sc_cmp_map();
    sc_clear();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire

// >>> otl_pkg.sv
// constants shared by the operating-time logger
// assumes one system clock at the rate below and a one-second time base
package otl_pkg;

  // ***************************************************************
  // clock and time base
  // ***************************************************************
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned TICK_PERIOD_NS = 1000000000;
  localparam int unsigned TICK_CYCLES_DEF = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 24;

  // ***************************************************************
  // counter layout
  // ***************************************************************
  localparam int unsigned TIME_W        = 20;
  localparam logic [TIME_W-1:0] TIME_ZERO  = 20'h00000;
  localparam logic [TIME_W-1:0] TIME_ONE   = 20'h00001;
  // 99,999.9 hours in tenths
  localparam logic [TIME_W-1:0] TENTHS_MAX = 20'hf423f;
  // 999,999 seconds
  localparam logic [TIME_W-1:0] SEC_MAX    = 20'hf423f;
  localparam int unsigned SEC_PER_TENTH = 360;
  localparam int unsigned SUB_W         = 9;
  localparam logic [SUB_W-1:0] SUB_ZERO = 9'h000;
  localparam logic [SUB_W-1:0] SUB_ONE  = 9'h001;
  localparam logic [SUB_W-1:0] SUB_LAST = SUB_W'(SEC_PER_TENTH - 1);

  // ***************************************************************
  // comparators and display selection
  // ***************************************************************
  localparam int unsigned GROUP_NUM     = 2;
  localparam int unsigned CMP_PER_GROUP = 3;
  localparam int unsigned CMP_NUM       = GROUP_NUM * CMP_PER_GROUP;
  localparam int unsigned SEL_W         = 3;
  localparam logic [SEL_W-1:0] SEL_OP   = 3'h0;

  // index 1..6 of comparator letter l (0=A) in group g (0=group 1)
  function automatic int unsigned cmp_index(input int unsigned g, input int unsigned l);
    return l * GROUP_NUM + g + 1;
  endfunction

endpackage
